// File: rtl/umac_pkg.sv
// umac_pkg: constants shared by the user memory access control block
// assumes: 13 blocks of 32 bits, block address 4 bits wide
package umac_pkg;
    localparam int BLK_W = 4;
    localparam int DATA_W = 32;
    localparam int CODE_W = 20;
    localparam logic [3:0] BLK_LUM_LAST = 4'h3;
    localparam logic [3:0] BLK_ASSIGN_FIRST = 4'h4;
    localparam logic [3:0] BLK_ASSIGN_LAST = 4'h8;
    localparam logic [3:0] BLK_MOD_FIRST = 4'h9;
    localparam logic [3:0] BLK_MOD_LAST = 4'hC;
    localparam logic [3:0] BLK_CTRL = 4'hB;
    localparam logic [3:0] BLK_CODE1 = 4'hC;
    localparam logic [3:0] BLK_CODE2 = 4'h3;
    localparam int CTRL_LSB = 0;
    localparam int CODE_LSB = 0;
    localparam logic [3:0] ASN_ALL1 = 4'h4;
    localparam logic [3:0] ASN_UP4 = 4'h5;
    localparam logic [3:0] ASN_UP5 = 4'h6;
    localparam logic [3:0] ASN_UP6 = 4'h7;
    localparam logic [3:0] ASN_UP7 = 4'h8;
    localparam logic [3:0] ASN_ALL2 = 4'h9;
    localparam logic [7:0] ERR_NO_ACCESS = 8'h0F;
    localparam logic [31:0] MASK_DATA = 32'h00000000;
    localparam logic [7:0] ERR_NONE = 8'h00;
    typedef enum logic [1:0] {
        UMAC_REQ_READ = 2'b00,
        UMAC_REQ_WRITE = 2'b01,
        UMAC_REQ_CODE = 2'b10
    } umac_req_t;
endpackage

// File: rtl/umac_map_if.sv
// umac_map_if: block to area lookup between top and the area mapper
// assumes: single clock, purely combinational lookup
`timescale 1ns/10ps
interface umac_map_if;
    logic [3:0] blk;
    logic [3:0] assign_field;
    logic in_area2;
    modport req (output blk, output assign_field, input in_area2);
    modport map (input blk, input assign_field, output in_area2);
endinterface

// File: rtl/umac_area_map.sv
// umac_area_map: decides whether a user block belongs to the luminaire area
// assumes: assignment field already read from the control block
`timescale 1ns/10ps
module umac_area_map (
    umac_map_if.map m
);
    // number of assignable blocks moved to area 2, counted up from block 04h
    function automatic logic [2:0] moved_count(input logic [3:0] f);
        unique case (f)
            umac_pkg::ASN_UP4: moved_count = 3'h1;
            umac_pkg::ASN_UP5: moved_count = 3'h2;
            umac_pkg::ASN_UP6: moved_count = 3'h3;
            umac_pkg::ASN_UP7: moved_count = 3'h4;
            umac_pkg::ASN_ALL2: moved_count = 3'h5;
            default: moved_count = 3'h0;  // ALL1 and every other value
        endcase
    endfunction

    logic [3:0] offs;
    always_comb begin
        offs = m.blk - umac_pkg::BLK_ASSIGN_FIRST;
        if (m.blk <= umac_pkg::BLK_LUM_LAST) begin
            m.in_area2 = 1'b1;
        end else if (m.blk >= umac_pkg::BLK_MOD_FIRST) begin
            m.in_area2 = 1'b0;
        end else begin
            m.in_area2 = ({1'b0, offs[2:0]} < {1'b0, moved_count(m.assign_field)});
        end
    end
endmodule

// File: rtl/umac_top.sv
// umac_top: access control in front of the 13-block user memory
// assumes: a command decoder presents one request per req_valid pulse, and the
// memory array answers reads combinationally through mem_rd_addr/mem_rd_data
`timescale 1ns/10ps
module umac_top #(
    parameter int NUM_BLOCKS = 13
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic power_off,
    input wire logic req_valid,
    input wire umac_pkg::umac_req_t req_kind,
    input wire logic [3:0] req_blk,
    input wire logic [31:0] req_wdata,
    input wire logic [3:0] req_wbe,
    input wire logic [19:0] req_code,
    output logic [3:0] mem_rd_addr,
    input wire logic [31:0] mem_rd_data,
    input wire logic [19:0] stored_code1,
    input wire logic [19:0] stored_code2,
    input wire logic [3:0] assign_field,
    output logic mem_wr_en,
    output logic [3:0] mem_wr_addr,
    output logic [31:0] mem_wr_data,
    output logic [3:0] mem_wr_be,
    output logic rsp_valid,
    output logic rsp_err,
    output logic [7:0] rsp_err_code,
    output logic [31:0] rsp_data,
    output logic auth1,
    output logic auth2
);
    ////////////////////////////////////////////////////////////////////////////
    umac_map_if map_i ();
    umac_area_map u_map (
        .m(map_i.map)
    );
    assign map_i.blk = req_blk;
    assign map_i.assign_field = assign_field;

    always_comb begin
        mem_rd_addr = req_blk;
    end

    logic blk_ok;
    logic is_code_blk;
    logic match1;
    logic match2;
    logic any_auth;
    logic wr_allowed;
    always_comb begin
        blk_ok = ({28'h0000000, req_blk} < NUM_BLOCKS);
        is_code_blk = (req_blk == umac_pkg::BLK_CODE1) || (req_blk == umac_pkg::BLK_CODE2);
        match1 = (req_code == stored_code1);
        match2 = (req_code == stored_code2);
        any_auth = auth1 || auth2;
        wr_allowed = blk_ok && (auth1 || (auth2 && map_i.in_area2));
    end

    ////////////////////////////////////////////////////////////////////////////
    // authorization flags: sticky until power-off, reset starts locked
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            auth1 <= 1'b0;
            auth2 <= 1'b0;
        end else if (power_off) begin
            auth1 <= 1'b0;
            auth2 <= 1'b0;
        end else if (req_valid && req_kind == umac_pkg::UMAC_REQ_CODE) begin
            // a mismatch leaves earlier grants alone, it only adds nothing
            if (match1) begin
                auth1 <= 1'b1;
            end
            if (match2) begin
                auth2 <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write path to memory
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_wr_en <= 1'b0;
            mem_wr_addr <= 4'h0;
            mem_wr_data <= 32'h00000000;
            mem_wr_be <= 4'h0;
        end else begin
            mem_wr_en <= req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_WRITE && wr_allowed;
            mem_wr_addr <= req_blk;
            mem_wr_data <= req_wdata;
            mem_wr_be <= req_wbe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // response path, one cycle after the request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_err_code <= umac_pkg::ERR_NONE;
            rsp_data <= umac_pkg::MASK_DATA;
        end else begin
            rsp_valid <= req_valid && !power_off;
            rsp_err <= 1'b0;
            rsp_err_code <= umac_pkg::ERR_NONE;
            rsp_data <= umac_pkg::MASK_DATA;
            if (req_valid) begin
                unique case (req_kind)
                    umac_pkg::UMAC_REQ_READ: begin
                        // code blocks never leave the chip, not even when authorized
                        if (any_auth && blk_ok && !is_code_blk) begin
                            rsp_data <= mem_rd_data;
                        end else begin
                            rsp_data <= umac_pkg::MASK_DATA;
                        end
                    end
                    umac_pkg::UMAC_REQ_WRITE: begin
                        if (!wr_allowed) begin
                            rsp_err <= 1'b1;
                            rsp_err_code <= umac_pkg::ERR_NO_ACCESS;
                        end
                    end
                    umac_pkg::UMAC_REQ_CODE: begin
                        rsp_err <= 1'b0;
                    end
                    default: begin
                        rsp_err <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_code_hit;
        req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_CODE && match1;
    endsequence

    a_auth1_grant: assert property (@(posedge clk) disable iff (sys_rst) s_code_hit |=> auth1)
        else $error("area 1 code match did not authorize");
    a_auth_poweroff: assert property (@(posedge clk) disable iff (sys_rst) power_off |=> !auth1 && !auth2)
        else $error("authorization survived power-off");
    a_auth_nomatch: assert property (@(posedge clk) disable iff (sys_rst)
        (!match1 && !auth1) |=> !auth1)
        else $error("authorization appeared without a match");
    a_code_masked: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && req_kind == umac_pkg::UMAC_REQ_READ && is_code_blk) |=> rsp_data == 32'h00000000)
        else $error("code block content leaked");
    a_read_unauth: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_READ && !any_auth)
        |=> rsp_valid && !rsp_err && rsp_data == 32'h00000000)
        else $error("unauthorized read not masked");
    a_read_served: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && req_kind == umac_pkg::UMAC_REQ_READ && any_auth && blk_ok && !is_code_blk)
        |=> rsp_data == $past(mem_rd_data))
        else $error("authorized read not served");
    a_write_denied: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_WRITE && !auth1 && !auth2)
        |=> !mem_wr_en && rsp_err && rsp_err_code == 8'h0F)
        else $error("unauthorized write not refused");
    a_write_area2: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && req_kind == umac_pkg::UMAC_REQ_WRITE && !auth1 && auth2 && !map_i.in_area2)
        |=> !mem_wr_en)
        else $error("area 2 code wrote outside area 2");
    a_write_area1: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_WRITE && auth1 && blk_ok)
        |=> mem_wr_en && mem_wr_addr == $past(req_blk))
        else $error("area 1 write not passed on");
    a_map_fixed: assert property (@(posedge clk) disable iff (sys_rst)
        (req_blk >= 4'h9 && req_blk <= 4'hC) |-> !map_i.in_area2)
        else $error("module block mapped to area 2");
    a_map_lum: assert property (@(posedge clk) disable iff (sys_rst)
        (req_blk <= 4'h3) |-> map_i.in_area2)
        else $error("luminaire block mapped to area 1");
    a_map_field: assert property (@(posedge clk) disable iff (sys_rst)
        (req_blk == 4'h6) |-> map_i.in_area2 == (assign_field == 4'h7 || assign_field == 4'h8
        || assign_field == 4'h9))
        else $error("block 06h mapping wrong");
    a_reset_locked: assert property (@(posedge clk) $fell(sys_rst) |-> !auth1 && !auth2)
        else $error("not locked after reset");

    ////////////////////////////////////////////////////////////////////////////
    // request shapes reused by the checks below
    sequence s_code_hit2;
        req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_CODE && match2;
    endsequence

    sequence s_code_req;
        req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_CODE;
    endsequence

    sequence s_read_req;
        req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_READ;
    endsequence

    sequence s_write_lum;
        req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_WRITE && !auth1 && auth2 && map_i.in_area2
        && blk_ok;
    endsequence

    sequence s_write_range;
        req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_WRITE && !blk_ok;
    endsequence

    // authorization: granted by a match, kept until power-off
    a_auth2_grant: assert property (@(posedge clk) disable iff (sys_rst)
        s_code_hit2 |=> auth2)
        else $error("area 2 code match did not authorize");
    a_auth2_nomatch: assert property (@(posedge clk) disable iff (sys_rst)
        (!match2 && !auth2) |=> !auth2)
        else $error("area 2 authorization appeared without a match");
    a_auth1_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (auth1 && !power_off) |=> auth1)
        else $error("area 1 authorization lost before power-off");
    a_auth2_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (auth2 && !power_off) |=> auth2)
        else $error("area 2 authorization lost before power-off");

    // responses: exactly one per accepted request, none while powered off
    a_power_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        power_off |=> !rsp_valid && !mem_wr_en)
        else $error("activity while powered off");
    a_rsp_follow: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && !power_off) |=> rsp_valid)
        else $error("request got no response");
    a_rsp_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !req_valid |=> !rsp_valid && !mem_wr_en)
        else $error("response or commit without a request");
    a_code_answer: assert property (@(posedge clk) disable iff (sys_rst)
        s_code_req |=> rsp_valid && !rsp_err)
        else $error("code request not answered cleanly");
    a_code_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_code_req |=> !mem_wr_en)
        else $error("code request wrote memory");
    a_read_no_err: assert property (@(posedge clk) disable iff (sys_rst)
        s_read_req |=> rsp_valid && !rsp_err)
        else $error("read answered with an error");
    a_read_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_read_req |=> !mem_wr_en)
        else $error("read request wrote memory");
    a_read_range: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && req_kind == umac_pkg::UMAC_REQ_READ && !blk_ok) |=> rsp_data == umac_pkg::MASK_DATA)
        else $error("read past the last block not masked");
    a_err_code: assert property (@(posedge clk) disable iff (sys_rst)
        rsp_err |-> rsp_err_code == umac_pkg::ERR_NO_ACCESS)
        else $error("error flag with wrong code");
    a_err_none: assert property (@(posedge clk) disable iff (sys_rst)
        !rsp_err |-> rsp_err_code == umac_pkg::ERR_NONE)
        else $error("error code without error flag");

    // writes: only what the permission allows reaches the memory, unchanged
    a_write_lum: assert property (@(posedge clk) disable iff (sys_rst)
        s_write_lum |=> mem_wr_en && !rsp_err)
        else $error("area 2 write inside area 2 refused");
    a_write_a1_ok: assert property (@(posedge clk) disable iff (sys_rst)
        (req_valid && !power_off && req_kind == umac_pkg::UMAC_REQ_WRITE && auth1 && blk_ok) |=> !rsp_err)
        else $error("area 1 write answered with an error");
    a_write_range: assert property (@(posedge clk) disable iff (sys_rst)
        s_write_range |=> !mem_wr_en && rsp_err && rsp_err_code == umac_pkg::ERR_NO_ACCESS)
        else $error("write past the last block not refused");
    a_write_pass: assert property (@(posedge clk) disable iff (sys_rst)
        mem_wr_en |-> mem_wr_addr == $past(req_blk) && mem_wr_data == $past(req_wdata)
        && mem_wr_be == $past(req_wbe))
        else $error("write reached memory altered");
    // a commit must always trace back to a write request of the cycle before
    a_write_cause: assert property (@(posedge clk) disable iff (sys_rst)
        mem_wr_en |-> $past(req_valid) && !$past(power_off)
        && $past(req_kind) == umac_pkg::UMAC_REQ_WRITE)
        else $error("commit without a write request");

    // the assignable window, block by block; 06h is checked above
    a_map_blk4: assert property (@(posedge clk) disable iff (sys_rst)
        (req_blk == 4'h4) |-> map_i.in_area2 == (assign_field >= umac_pkg::ASN_UP4
        && assign_field <= umac_pkg::ASN_ALL2))
        else $error("block 04h mapping wrong");
    a_map_blk5: assert property (@(posedge clk) disable iff (sys_rst)
        (req_blk == 4'h5) |-> map_i.in_area2 == (assign_field >= umac_pkg::ASN_UP5
        && assign_field <= umac_pkg::ASN_ALL2))
        else $error("block 05h mapping wrong");
    a_map_blk7: assert property (@(posedge clk) disable iff (sys_rst)
        (req_blk == 4'h7) |-> map_i.in_area2 == (assign_field >= umac_pkg::ASN_UP7
        && assign_field <= umac_pkg::ASN_ALL2))
        else $error("block 07h mapping wrong");
    a_map_blk8: assert property (@(posedge clk) disable iff (sys_rst)
        (req_blk == 4'h8) |-> map_i.in_area2 == (assign_field == umac_pkg::ASN_ALL2))
        else $error("block 08h mapping wrong");
    a_map_other: assert property (@(posedge clk) disable iff (sys_rst)
        (req_blk >= umac_pkg::BLK_ASSIGN_FIRST && req_blk <= umac_pkg::BLK_ASSIGN_LAST
        && (assign_field < umac_pkg::ASN_UP4 || assign_field > umac_pkg::ASN_ALL2)) |-> !map_i.in_area2)
        else $error("unlisted field moved a block to area 2");
endmodule

// File: tb/umac_mem_model.sv
// umac_mem_model: the 13-word user memory behind the access control
// assumes: umac_top commits writes, reads are combinational
`timescale 1ns/10ps
module umac_mem_model (
    input wire logic clk,
    input wire logic [3:0] rd_addr,
    output logic [31:0] rd_data,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_be,
    output logic [19:0] code1,
    output logic [19:0] code2,
    output logic [3:0] field
);
    logic [31:0] mem [0:12];
    // unmapped words show the address, never a stale word
    assign rd_data = (rd_addr <= 4'hC) ? mem[rd_addr] : {8{rd_addr}};
    assign code1 = mem[12][19:0];
    assign code2 = mem[3][19:0];
    assign field = mem[11][3:0];
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (wr_en && wr_addr <= 4'hC && wr_be[i]) begin
                mem[wr_addr][8*i +: 8] <= wr_data[8*i +: 8];
            end
        end
    end
endmodule

// File: tb/umac_top_tb.sv
// umac_top_tb: self-checking bench for the access control
// assumes: umac_mem_model stands in for the memory array
`timescale 1ns/10ps
module umac_top_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic power_off = 1'b0;
    logic req_valid = 1'b0;
    umac_pkg::umac_req_t req_kind = umac_pkg::UMAC_REQ_READ;
    logic [3:0] req_blk = 4'h0;
    logic [31:0] req_wdata = 32'h00000000;
    logic [3:0] req_wbe = 4'hF;
    logic [19:0] req_code = 20'h00000;
    logic [3:0] rd_addr, wr_addr, wr_be, field;
    logic [31:0] rd_data, wr_data, rsp_data, got_data, old;
    logic [19:0] code1, code2;
    logic wr_en, rsp_valid, rsp_err, auth1, auth2, got_wr, ok;
    logic [7:0] rsp_err_code;
    logic [9:0] got_st;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    umac_top dut_u (.clk(clk), .sys_rst(sys_rst), .power_off(power_off), .req_valid(req_valid),
        .req_kind(req_kind), .req_blk(req_blk), .req_wdata(req_wdata), .req_wbe(req_wbe), .req_code(req_code),
        .mem_rd_addr(rd_addr), .mem_rd_data(rd_data), .stored_code1(code1), .stored_code2(code2),
        .assign_field(field), .mem_wr_en(wr_en), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data),
        .mem_wr_be(wr_be), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_err_code(rsp_err_code),
        .rsp_data(rsp_data), .auth1(auth1), .auth2(auth2));
    umac_mem_model mem_u (.clk(clk), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_be(wr_be), .code1(code1), .code2(code2), .field(field));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one request, answer captured the cycle after it is taken
    task automatic send(input umac_pkg::umac_req_t k, input logic [3:0] b, input logic [31:0] d,
        input logic [19:0] c);
        @(negedge clk);
        req_kind = k;
        req_blk = b;
        req_wdata = d;
        req_code = c;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        got_st = {rsp_valid, rsp_err, rsp_err_code};
        got_data = rsp_data;
        got_wr = wr_en;
    endtask
    function automatic logic in_a2(input logic [3:0] b, input logic [3:0] f);
        if (b <= 4'h3) return 1'b1;
        if (b >= 4'h9) return 1'b0;
        return f >= 4'h5 && f <= 4'h9 && b < f;
    endfunction
    ////////////////////////////////////////////////////////////
    task automatic t_unauth();
        chk({30'h0, auth1, auth2}, 32'h0);
        for (int b = 0; b < 13; b++) begin
            send(umac_pkg::UMAC_REQ_READ, 4'(b), 32'h0, 20'h0);
            chk({22'h0, got_st}, 32'h200);
            chk(got_data, 32'h00000000);
        end
        old = mem_u.mem[9];
        send(umac_pkg::UMAC_REQ_WRITE, 4'h9, 32'h12345678, 20'h0);
        chk({22'h0, got_st}, 32'h30F);
        @(negedge clk);
        chk(mem_u.mem[9], old);
        send(umac_pkg::UMAC_REQ_CODE, 4'h0, 32'h0, code1 ^ 20'h00001);
        chk({22'h0, got_st}, 32'h200);
        chk({30'h0, auth1, auth2}, 32'h0);
    endtask
    task automatic t_area2();
        send(umac_pkg::UMAC_REQ_CODE, 4'h0, 32'h0, code2);
        chk({22'h0, got_st}, 32'h200);
        chk({30'h0, auth1, auth2}, 32'h1);
        for (int f = 0; f < 16; f++) begin
            mem_u.mem[11][3:0] = 4'(f);
            for (int b = 0; b < 13; b++) begin
                old = mem_u.mem[b];
                ok = in_a2(4'(b), 4'(f));
                send(umac_pkg::UMAC_REQ_WRITE, 4'(b), {4'(f), 4'(b), 24'h5A5A5A}, 20'h0);
                chk({22'h0, got_st}, ok ? 32'h200 : 32'h30F);
                chk({31'h0, got_wr}, {31'h0, ok});
                @(negedge clk);
                chk(mem_u.mem[b], ok ? {4'(f), 4'(b), 24'h5A5A5A} : old);
            end
        end
        for (int b = 0; b < 13; b++) begin
            send(umac_pkg::UMAC_REQ_READ, 4'(b), 32'h0, 20'h0);
            chk(got_data, (b == 3 || b == 12) ? 32'h00000000 : mem_u.mem[b]);
        end
    endtask
    task automatic t_area1();
        send(umac_pkg::UMAC_REQ_CODE, 4'h0, 32'h0, code1);
        chk({30'h0, auth1, auth2}, 32'h3);
        old = mem_u.mem[12];
        req_wbe = 4'h2;
        send(umac_pkg::UMAC_REQ_WRITE, 4'hC, 32'hFFFFFFFF, 20'h0);
        req_wbe = 4'hF;
        chk({22'h0, got_st}, 32'h200);
        @(negedge clk);
        chk(mem_u.mem[12], {old[31:16], 8'hFF, old[7:0]});
        send(umac_pkg::UMAC_REQ_READ, 4'hC, 32'h0, 20'h0);
        chk(got_data, 32'h00000000);
        send(umac_pkg::UMAC_REQ_READ, 4'hD, 32'h0, 20'h0);
        chk(got_data, 32'h00000000);
        send(umac_pkg::UMAC_REQ_WRITE, 4'hE, 32'h0, 20'h0);
        chk({22'h0, got_st}, 32'h30F);
        chk({31'h0, got_wr}, 32'h0);
    endtask
    task automatic t_power_off();
        @(negedge clk);
        power_off = 1'b1;
        repeat (2) @(negedge clk);
        send(umac_pkg::UMAC_REQ_CODE, 4'h0, 32'h0, code2);
        chk({22'h0, got_st}, 32'h000);
        power_off = 1'b0;
        chk({30'h0, auth1, auth2}, 32'h0);
        send(umac_pkg::UMAC_REQ_READ, 4'h5, 32'h0, 20'h0);
        chk(got_data, 32'h00000000);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        for (int i = 0; i < 13; i++) begin
            mem_u.mem[i] = i * 32'h11111111;
        end
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        t_unauth();
        t_area2();
        t_area1();
        t_power_off();
        summarize();
    end
endmodule
